// File: core/aprd_edge_sync.sv
// Two-stage synchroniser for one pin, followed by a rising-edge detector.
`timescale 1ns/1ps
module aprd_edge_sync
   import aprd_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Asynchronous pin.
   input wire logic pin,
   // Synchronised level and its rising edge.
   output logic level,
   output logic rise
);

   logic meta;
   logic prev;

   // The first stage is read only by the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'h0;
         level <= 1'h0;
         prev <= 1'h0;
      end else if (clk_en) begin
         meta <= pin;
         level <= meta;
         prev <= level;
      end
   end

   // One-cycle pulse on each rising edge of the synchronised level.
   assign rise = level & ~prev;

endmodule

// File: core/aprd_pkg.sv
// Shared constants, register map, rate band tables and state types for the rate detector.
package aprd_pkg;

   // Core clock rate, used to turn a frame period in cycles into a rate.
   localparam int unsigned APRD_CLK_HZ = 250_000_000;
   localparam int unsigned APRD_CLK_PERIOD_NS = 4;

   // Register indices; the byte address of each is four times its index.
   localparam int APRD_IDX_LSB = 2;
   localparam int APRD_IDX_W = 8;
   localparam logic [7:0] APRD_IDX_RATE = 8'h3f;
   localparam logic [7:0] APRD_IDX_RATIO_HI = 8'h40;
   localparam logic [7:0] APRD_IDX_RATIO_LO = 8'h41;
   localparam logic [7:0] APRD_IDX_CTRL = 8'h50;
   localparam logic [7:0] APRD_IDX_DSTAT = 8'h51;

   // Field layout and widths.
   localparam int APRD_REG_W = 8;
   localparam int APRD_CODE_W = 6;
   localparam int APRD_RATE_CODE_LSB = 2;
   localparam int APRD_RATIO_W = 14;
   localparam int APRD_RATIO_LOW_W = 8;
   localparam int APRD_RATIO_HIGH_W = 6;
   localparam int APRD_CTRL_PORT_SEL_BIT = 0;
   localparam int APRD_DSTAT_RATE_VALID_BIT = 0;
   localparam int APRD_DSTAT_RATIO_VALID_BIT = 1;
   localparam int APRD_DSTAT_RATIO_SAT_BIT = 2;

   // Reset values.
   localparam logic [7:0] APRD_STATUS_RESET = 8'h00;
   localparam logic [7:0] APRD_CTRL_RESET = 8'h00;
   localparam logic [5:0] APRD_CODE_RESET = 6'h00;

   // Bus response codes.
   localparam logic [1:0] APRD_RESP_OKAY = 2'h0;
   localparam logic [1:0] APRD_RESP_DECERR = 2'h3;

   // Band codes: zero means nothing detected, 41 to 63 are never produced.
   localparam logic [5:0] APRD_CODE_NONE = 6'h00;
   localparam logic [5:0] APRD_BAND_FIRST = 6'h01;
   localparam logic [5:0] APRD_BAND_LAST = 6'h28;

   // Lower and upper edge of each band in Hz, indexed by band code.
   localparam int unsigned APRD_BAND_LO_HZ [1:40] = '{
      670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440, 191520, 167580,
      148960, 134064, 111720, 95760, 83790, 74480, 67032, 55860, 47880, 41895,
      37240, 33516, 27930, 23940, 20947, 18620, 16758, 13965, 11970, 10473,
      9310, 8379, 6982, 5985, 5236, 4655, 4189, 3491, 2992, 2618};
   localparam int unsigned APRD_BAND_HI_HZ [1:40] = '{
      791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680, 226011, 197760,
      175786, 158208, 131840, 113005, 98880, 87893, 79104, 65920, 56502, 49440,
      43946, 39552, 32960, 28251, 24720, 21973, 19776, 16480, 14125, 12360,
      10986, 9888, 8240, 7062, 6180, 5493, 4944, 4120, 3531, 3090};

   // Register selected by a bus address.
   typedef enum logic [5:0] {
      APRD_REG_NONE = 6'h01,
      APRD_REG_RATE = 6'h02,
      APRD_REG_RATIO_HI = 6'h04,
      APRD_REG_RATIO_LO = 6'h08,
      APRD_REG_CTRL = 6'h10,
      APRD_REG_DSTAT = 6'h20
   } aprd_reg_e;

   // Band search states.
   typedef enum logic [1:0] {
      APRD_CLS_IDLE = 2'h1,
      APRD_CLS_SCAN = 2'h2
   } aprd_cls_state_e;

endpackage

// File: core/aprd_rate_classify.sv
// Sequential band search that turns a frame period in cycles into a rate band code.
`timescale 1ns/1ps
module aprd_rate_classify
   import aprd_pkg::*;
#(
   parameter int PERIOD_W = 20
)
(
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Measured period and a start pulse; ignored while busy.
   input wire logic start,
   input wire logic [PERIOD_W-1:0] period,
   // Search status and result.
   output logic busy,
   output logic done,
   output logic [APRD_CODE_W-1:0] code
);

   localparam int PROD_W = PERIOD_W + 32;

   aprd_cls_state_e state;
   logic [PERIOD_W-1:0] period_q;
   logic [APRD_CODE_W-1:0] idx;
   logic [PROD_W-1:0] prod_lo;
   logic [PROD_W-1:0] prod_hi;
   logic [PROD_W-1:0] clk_hz_w;
   logic match;

   // One multiplier pair walks the bands, one per cycle, instead of forty in parallel.
   assign clk_hz_w = PROD_W'(APRD_CLK_HZ);
   assign prod_lo = PROD_W'(period_q) * PROD_W'(APRD_BAND_LO_HZ[idx]);
   assign prod_hi = PROD_W'(period_q) * PROD_W'(APRD_BAND_HI_HZ[idx]);
   // Rate is in the band when lo <= clk/period <= hi.
   assign match = (prod_lo <= clk_hz_w) && (prod_hi >= clk_hz_w);
   assign busy = (state == APRD_CLS_SCAN);

   // Neighbouring bands overlap, so the search runs from the slowest band up: the first
   // match is then the band whose nominal rate the frame is nearest to.
   // A period in no band gives code zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= APRD_CLS_IDLE;
         period_q <= '0;
         idx <= APRD_BAND_LAST;
         done <= 1'h0;
         code <= APRD_CODE_RESET;
      end else if (clk_en) begin
         done <= 1'h0;
         case (state)
            APRD_CLS_IDLE: begin
               if (start) begin
                  period_q <= period;
                  idx <= APRD_BAND_LAST;
                  state <= APRD_CLS_SCAN;
               end
            end
            APRD_CLS_SCAN: begin
               if (match) begin
                  code <= idx;
                  done <= 1'h1;
                  state <= APRD_CLS_IDLE;
               end else if (idx == APRD_BAND_FIRST) begin
                  code <= APRD_CODE_NONE;
                  done <= 1'h1;
                  state <= APRD_CLS_IDLE;
               end else begin
                  // Step one code towards the faster bands.
                  idx <= idx - APRD_BAND_FIRST;
               end
            end
            default: begin
               state <= APRD_CLS_IDLE;
            end
         endcase
      end
   end

endmodule

// File: core/aprd_top.sv
// Audio port rate and frame-to-clock ratio detector with an AXI4-Lite status interface.
//
// Notes on behaviour
// - The secondary port frame rate is shown as a six-bit band code in bits 7 to 2, and zero is never a detection.
// - A secondary frame rate from 670320 to 791040 Hz gives code 1, nominal 768000 Hz.
// - A rate above 43946 and up to 49440 Hz gives code 20, nominal 48000 Hz, and every other code is banded the same way.
// - Code 40 covers 2618 to 3090 Hz as the slowest band, and codes 41 to 63 are never reported.
// - Bits 1 and 0 of the secondary rate register always read as zero.
// - The six high bits of the frame-to-clock ratio of the selected port sit in bits 5 to 0 of the next register, with bits 7 and 6 zero.
// - Both detection registers at indices 0x3F and 0x40 reset to zero and ignore writes.
// - The low eight ratio bits sit in their own read-only register at index 0x41.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module aprd_top
   import aprd_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int PERIOD_W = 20
)
(
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Audio pins, asynchronous to ref_clk.
   input wire logic pri_fsync_pin,
   input wire logic sec_fsync_pin,
   input wire logic clk_src_pin,
   // AXI4-Lite write address channel.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int NUM_PINS = 3;
   localparam int PIN_PRI = 0;
   localparam int PIN_SEC = 1;
   localparam int PIN_CLK = 2;
   localparam logic [APRD_RATIO_W-1:0] RATIO_MAX = '1;
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = '1;
   localparam logic [PERIOD_W-1:0] PERIOD_ONE = PERIOD_W'(1);
   localparam logic [APRD_RATIO_W-1:0] RATIO_ONE = APRD_RATIO_W'(1);

   // Reset synchroniser.
   logic rst_meta_n;
   logic rst_sync_n;
   // Pin sampling.
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] pin_rise;
   // Software control and detection results.
   logic [APRD_REG_W-1:0] ctrl;
   logic [APRD_CODE_W-1:0] secondary_port_rate_code;
   logic [APRD_RATIO_W-1:0] frame_clock_ratio;
   logic rate_valid;
   logic ratio_valid;
   logic ratio_sat;
   // Secondary period measurement.
   logic [PERIOD_W-1:0] period_cnt;
   logic sec_armed;
   logic cls_start;
   logic cls_busy;
   logic cls_done;
   logic [APRD_CODE_W-1:0] cls_code;
   // Ratio measurement.
   logic port_sel;
   logic port_sel_prev;
   logic sel_rise;
   logic ratio_armed;
   logic [APRD_RATIO_W-1:0] ratio_cnt;
   // Write path holding state.
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   aprd_reg_e wr_sel;
   aprd_reg_e rd_sel;

   // Address decode shared by the read and write paths.
   function automatic aprd_reg_e decode_addr(input logic [ADDR_W-1:0] addr);
      logic [APRD_IDX_W-1:0] idx;
      logic upper_zero;
      idx = addr[APRD_IDX_LSB +: APRD_IDX_W];
      upper_zero = (addr[ADDR_W-1:APRD_IDX_LSB+APRD_IDX_W] == '0);
      if (!upper_zero) begin
         decode_addr = APRD_REG_NONE;
      end else if (idx == APRD_IDX_RATE) begin
         decode_addr = APRD_REG_RATE;
      end else if (idx == APRD_IDX_RATIO_HI) begin
         decode_addr = APRD_REG_RATIO_HI;
      end else if (idx == APRD_IDX_RATIO_LO) begin
         decode_addr = APRD_REG_RATIO_LO;
      end else if (idx == APRD_IDX_CTRL) begin
         decode_addr = APRD_REG_CTRL;
      end else if (idx == APRD_IDX_DSTAT) begin
         decode_addr = APRD_REG_DSTAT;
      end else begin
         decode_addr = APRD_REG_NONE;
      end
   endfunction

   // Release of the asynchronous reset is retimed so all flops leave reset together.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'h0;
         rst_sync_n <= 1'h0;
      end else if (clk_en) begin
         rst_meta_n <= 1'h1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Every audio pin passes two flops; the clock source must stay below half of ref_clk.
   assign pin_raw = {clk_src_pin, sec_fsync_pin, pri_fsync_pin};
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         aprd_edge_sync u_sync (
            .clk(ref_clk),
            .rst_n(rst_sync_n),
            .clk_en(clk_en),
            .pin(pin_raw[gi]),
            .level(pin_level[gi]),
            .rise(pin_rise[gi])
         );
      end
   endgenerate

   // Cycles between secondary frame edges; the first edge only arms the counter.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         period_cnt <= '0;
         sec_armed <= 1'h0;
      end else if (clk_en) begin
         if (pin_rise[PIN_SEC]) begin
            period_cnt <= PERIOD_ONE;
            sec_armed <= 1'h1;
         end else if (period_cnt != PERIOD_MAX) begin
            period_cnt <= period_cnt + PERIOD_ONE;
         end
      end
   end

   // A new search starts per frame; frames arriving mid-search are skipped, not queued.
   assign cls_start = pin_rise[PIN_SEC] && sec_armed && !cls_busy;

   aprd_rate_classify #(
      .PERIOD_W(PERIOD_W)
   ) u_classify (
      .clk(ref_clk),
      .rst_n(rst_sync_n),
      .clk_en(clk_en),
      .start(cls_start),
      .period(period_cnt),
      .busy(cls_busy),
      .done(cls_done),
      .code(cls_code)
   );

   // The reported code moves only when a search completes.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         secondary_port_rate_code <= APRD_CODE_RESET;
         rate_valid <= 1'h0;
      end else if (clk_en && cls_done) begin
         secondary_port_rate_code <= cls_code;
         rate_valid <= (cls_code != APRD_CODE_NONE);
      end
   end

   // Port for the ratio count, chosen by software: zero primary, one secondary.
   assign port_sel = ctrl[APRD_CTRL_PORT_SEL_BIT];
   assign sel_rise = port_sel ? pin_rise[PIN_SEC] : pin_rise[PIN_PRI];

   // Clock source edges per frame of the selected port, saturating at the field width.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         port_sel_prev <= 1'h0;
         ratio_armed <= 1'h0;
         ratio_cnt <= '0;
         frame_clock_ratio <= '0;
         ratio_valid <= 1'h0;
         ratio_sat <= 1'h0;
      end else if (clk_en) begin
         port_sel_prev <= port_sel;
         if (port_sel != port_sel_prev) begin
            // A switch of port discards the partial frame rather than mixing two ports.
            ratio_armed <= 1'h0;
            ratio_cnt <= '0;
         end else if (sel_rise) begin
            ratio_armed <= 1'h1;
            ratio_cnt <= pin_rise[PIN_CLK] ? RATIO_ONE : '0;
            if (ratio_armed) begin
               frame_clock_ratio <= ratio_cnt;
               ratio_valid <= 1'h1;
               ratio_sat <= (ratio_cnt == RATIO_MAX);
            end
         end else if (pin_rise[PIN_CLK] && ratio_armed && ratio_cnt != RATIO_MAX) begin
            ratio_cnt <= ratio_cnt + RATIO_ONE;
         end
      end
   end

   assign wr_sel = decode_addr(aw_addr);
   assign rd_sel = decode_addr(s_axi_araddr);

   // Write address and data are taken in either order and held until the response.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_awready <= 1'h0;
         s_axi_wready <= 1'h0;
         aw_got <= 1'h0;
         w_got <= 1'h0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'h0;
            aw_got <= 1'h1;
            aw_addr <= s_axi_awaddr;
         end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'h1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'h0;
            w_got <= 1'h1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'h1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            aw_got <= 1'h0;
            w_got <= 1'h0;
         end
      end
   end

   // Response once both halves are held; status registers accept writes with no effect.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= APRD_RESP_OKAY;
         ctrl <= APRD_CTRL_RESET;
      end else if (clk_en) begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
         end else if (aw_got && w_got && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= (wr_sel == APRD_REG_NONE) ? APRD_RESP_DECERR : APRD_RESP_OKAY;
            if (wr_sel == APRD_REG_CTRL && w_strb[0]) begin
               // Only the port select bit is stored; the rest reads as zero.
               ctrl <= APRD_CTRL_RESET;
               ctrl[APRD_CTRL_PORT_SEL_BIT] <= w_data[APRD_CTRL_PORT_SEL_BIT];
            end
         end
      end
   end

   // Reads return the selected register in the low byte and have no side effect.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= '0;
         s_axi_rresp <= APRD_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h1;
            s_axi_rresp <= APRD_RESP_OKAY;
            s_axi_rdata <= '0;
            if (rd_sel == APRD_REG_RATE) begin
               // Low two bits stay zero.
               s_axi_rdata[APRD_RATE_CODE_LSB +: APRD_CODE_W] <= secondary_port_rate_code;
            end else if (rd_sel == APRD_REG_RATIO_HI) begin
               // Bits 7 and 6 stay zero.
               s_axi_rdata[APRD_RATIO_HIGH_W-1:0] <=
                  frame_clock_ratio[APRD_RATIO_W-1:APRD_RATIO_LOW_W];
            end else if (rd_sel == APRD_REG_RATIO_LO) begin
               s_axi_rdata[APRD_RATIO_LOW_W-1:0] <=
                  frame_clock_ratio[APRD_RATIO_LOW_W-1:0];
            end else if (rd_sel == APRD_REG_CTRL) begin
               s_axi_rdata[APRD_REG_W-1:0] <= ctrl;
            end else if (rd_sel == APRD_REG_DSTAT) begin
               s_axi_rdata[APRD_DSTAT_RATE_VALID_BIT] <= rate_valid;
               s_axi_rdata[APRD_DSTAT_RATIO_VALID_BIT] <= ratio_valid;
               s_axi_rdata[APRD_DSTAT_RATIO_SAT_BIT] <= ratio_sat;
            end else begin
               s_axi_rresp <= APRD_RESP_DECERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
            s_axi_arready <= 1'h1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'h1;
         end
      end
   end

   // Unused level outputs of the synchronisers are kept for debug probing.
   logic unused_levels;
   assign unused_levels = ^pin_level;

endmodule

// File: verif/aprd_top_sva.sv
// Bus-side assertions for the rate detector top, bound to its ports.
`timescale 1ns/1ps
module aprd_top_sva
   import aprd_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Write side.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read side.
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [ADDR_W-3:0] rd_idx;
   logic [ADDR_W-3:0] wr_idx;
   logic rd_map;
   logic wr_map;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // The answer does not carry its address, so the index is kept from the request.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_idx <= '0;
         wr_idx <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[ADDR_W-1:2];
         if (s_axi_awvalid && s_axi_awready) wr_idx <= s_axi_awaddr[ADDR_W-1:2];
      end
   end
   // Only five word indices decode; every other one must be refused.
   assign rd_map = rd_idx inside {APRD_IDX_RATE, APRD_IDX_RATIO_HI, APRD_IDX_RATIO_LO,
      APRD_IDX_CTRL, APRD_IDX_DSTAT};
   assign wr_map = wr_idx inside {APRD_IDX_RATE, APRD_IDX_RATIO_HI, APRD_IDX_RATIO_LO,
      APRD_IDX_CTRL, APRD_IDX_DSTAT};
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped or changed");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped or changed");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above byte not zero");
   a_rate_low_zero: assert property (s_axi_rvalid && rd_idx == APRD_IDX_RATE
      |-> s_axi_rdata[1:0] == 2'h0)
      else $error("rate register low bits not zero");
   a_rate_no_reserved: assert property (s_axi_rvalid && rd_idx == APRD_IDX_RATE
      |-> s_axi_rdata[7:2] <= APRD_BAND_LAST)
      else $error("reserved band code reported");
   a_ratio_top_zero: assert property (s_axi_rvalid && rd_idx == APRD_IDX_RATIO_HI
      |-> s_axi_rdata[7:6] == 2'h0)
      else $error("ratio high register top bits not zero");
   a_read_decode: assert property (s_axi_rvalid |-> (rd_map ?
      s_axi_rresp == APRD_RESP_OKAY : (s_axi_rresp == APRD_RESP_DECERR && s_axi_rdata == 0)))
      else $error("read response wrong for address");
   a_write_decode: assert property (s_axi_bvalid |-> s_axi_bresp ==
      (wr_map ? APRD_RESP_OKAY : APRD_RESP_DECERR))
      else $error("write response wrong for address");
endmodule
bind aprd_top aprd_top_sva #(.ADDR_W(ADDR_W)) u_aprd_top_sva (.ref_clk(ref_clk), .rst_n(rst_n),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// File: verif/tb.sv
// Self-checking bench for the rate detector: bus tasks, pin stimulus and status checks.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   import aprd_pkg::*;
   localparam logic [11:0] A_RATE = 12'h0fc;
   localparam logic [11:0] A_HI = 12'h100;
   localparam logic [11:0] A_LO = 12'h104;
   localparam logic [11:0] A_CTRL = 12'h140;
   localparam logic [11:0] A_DST = 12'h144;
   localparam logic [11:0] A_BAD = 12'h200;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pri_fsync = 1'b0;
   logic sec_fsync = 1'b0;
   logic clk_src = 1'b0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int last_rise = 0;
   aprd_top u_aprd_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .pri_fsync_pin(pri_fsync), .sec_fsync_pin(sec_fsync), .clk_src_pin(clk_src),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // A 4 ns clock.
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // Clock source at one eighth of the core rate, primary frames every 2400 cycles (ratio 300).
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      clk_src <= cyc[2];
      pri_fsync <= (cyc % 2400) < 8;
   end
   // Offers address and data together, drops each when taken, then waits for the answer.
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge ref_clk);
         if (aw_p && awready) begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && wready) begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // Reads one word and compares data and response with the expected pair.
   task automatic chk_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      `CHK(rd, ed)
      `CHK(rs, er)
   endtask
   // Raises a secondary frame edge exactly per cycles after the previous one.
   task automatic sec_at(input int per);
      do @(posedge ref_clk); while (cyc != last_rise + per);
      sec_fsync <= 1'b1;
      last_rise = cyc;
      repeat (8) @(posedge ref_clk);
      sec_fsync <= 1'b0;
   endtask
   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chk_rd(A_RATE, 32'h0, APRD_RESP_OKAY);
      chk_rd(A_HI, 32'h0, APRD_RESP_OKAY);
      chk_rd(A_LO, 32'h0, APRD_RESP_OKAY);
      chk_rd(A_BAD, 32'h0, APRD_RESP_DECERR);
      axi_write(A_RATE, 32'h000000ff, rs);
      `CHK(rs, APRD_RESP_OKAY)
      axi_write(A_HI, 32'h0000003f, rs);
      `CHK(rs, APRD_RESP_OKAY)
      axi_write(A_BAD, 32'h00000001, rs);
      `CHK(rs, APRD_RESP_DECERR)
      chk_rd(A_RATE, 32'h0, APRD_RESP_OKAY);
      chk_rd(A_HI, 32'h0, APRD_RESP_OKAY);
      $display("test 1 done: reset values and read-only");
      repeat (5000) @(posedge ref_clk);
      chk_rd(A_HI, 32'h01, APRD_RESP_OKAY);
      chk_rd(A_LO, 32'h2c, APRD_RESP_OKAY);
      chk_rd(A_HI, 32'h01, APRD_RESP_OKAY);
      $display("test 2 done: primary ratio");
      axi_write(A_CTRL, 32'h00000001, rs);
      `CHK(rs, APRD_RESP_OKAY)
      chk_rd(A_CTRL, 32'h01, APRD_RESP_OKAY);
      last_rise = cyc;
      sec_at(20);
      sec_at(326);
      repeat (80) @(posedge ref_clk);
      chk_rd(A_RATE, 32'h04, APRD_RESP_OKAY);
      sec_at(5208);
      repeat (80) @(posedge ref_clk);
      chk_rd(A_RATE, 32'h50, APRD_RESP_OKAY);
      chk_rd(A_HI, 32'h02, APRD_RESP_OKAY);
      chk_rd(A_LO, 32'h8b, APRD_RESP_OKAY);
      chk_rd(A_DST, 32'h03, APRD_RESP_OKAY);
      $display("test 3 done: fast bands and secondary ratio");
      // Reads during a long frame must leave the held code alone.
      fork
         sec_at(83333);
         begin
            repeat (40000) @(posedge ref_clk);
            chk_rd(A_RATE, 32'h50, APRD_RESP_OKAY);
            chk_rd(A_RATE, 32'h50, APRD_RESP_OKAY);
         end
      join
      repeat (80) @(posedge ref_clk);
      chk_rd(A_RATE, 32'ha0, APRD_RESP_OKAY);
      $display("test 4 done: slowest band");
      complete_run();
   end
   // Cuts a hang short; the sequence needs about 94000 cycles.
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      complete_run();
   end
endmodule
